/* File: design/rpsel_pkg.sv */
// Constants and carrier types for the peripheral remap fabric.
// Assumes a 32-bit classic Wishbone master and a 200 MHz system clock.
package rpsel_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_PINS   = 8;   // Remappable output pins
    localparam int NUM_POUT   = 10;  // Peripheral outputs, codes 1..10
    localparam int NUM_PIN_IN = 4;   // Peripheral inputs with selectors
    localparam int SEL_W      = 4;   // Width of every selection field

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] CFG_CTRL_OFS = 8'h00; // config_control_reg
    localparam logic [7:0] UNLOCK_OFS   = 8'h04; // Unlock key register
    localparam logic [7:0] STATUS_OFS   = 8'h08; // Lock/fuse/key state
    localparam logic [7:0] OUT_SEL_OFS  = 8'h40; // output_pin_select_reg 0
    localparam logic [7:0] IN_SEL_OFS   = 8'h80; // Input select 0

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int LOCK_BIT       = 13; // map_write_lock
    localparam int FUSE_CFG_BIT   = 29; // single_session_lock_fuse
    localparam int ST_LOCK_BIT    = 0;
    localparam int ST_FUSE_BIT    = 1;
    localparam int ST_UNLOCK_BIT  = 2;
    localparam logic             LOCK_RST = 1'b0;
    localparam logic             FUSE_RST = 1'b1; // Unprogrammed reads set
    localparam logic [SEL_W-1:0] SEL_RST  = 4'h0; // Null route on output pins; input selectors pick pad 0

    // Unlock keys, values arbitrary
    localparam logic [31:0] UNLOCK_KEY1 = 32'h1234_abcd;
    localparam logic [31:0] UNLOCK_KEY2 = 32'hedcb_5678;

    // ------------------------------------------------------------------
    // Bus carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } rpsel_wb_req_t;

endpackage

/* File: design/rpsel_top.sv */
// Peripheral remap fabric: per-pin output routing with write lock.
// Assumes peripheral outputs share sys_clk_in; pad inputs are async.
`timescale 1ns/1ps
module rpsel_top (
    input  wire logic                             sys_clk_in,
    input  wire logic                             arst_n_in,
    input  wire rpsel_pkg::rpsel_wb_req_t         wb_req_in,
    output logic                                  wb_ack_out,
    output logic [31:0]                           wb_dat_out,
    input  wire logic [31:0]                      cfg_word3_in,
    input  wire logic [rpsel_pkg::NUM_POUT-1:0]   periph_out_in,
    output logic [rpsel_pkg::NUM_PINS-1:0]        pin_out_out,
    output logic [rpsel_pkg::NUM_PINS-1:0]        pin_oe_out,
    input  wire logic [rpsel_pkg::NUM_PINS-1:0]   pin_in_in,
    output logic [rpsel_pkg::NUM_PIN_IN-1:0]      periph_in_out,
    output logic                                  map_write_lock_out
);

    localparam int NP = rpsel_pkg::NUM_PINS;
    localparam int NO = rpsel_pkg::NUM_POUT;
    localparam int NI = rpsel_pkg::NUM_PIN_IN;
    localparam int SW = rpsel_pkg::SEL_W;

    // Merge byte lanes of a write into an old word
    function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // True when a code names an implemented peripheral output
    function automatic logic code_valid(input logic [SW-1:0] c);
        return (c != 4'h0) && ({28'h0, c} <= 32'(NO));
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [SW-1:0] out_sel_ff [NP];
    logic [SW-1:0] in_sel_ff  [NI];
    logic          lock_ff;
    logic          nxt_lock;
    logic          key1_ff;
    logic          unlocked_ff;
    logic          ack_ff;
    logic [31:0]   rdat_ff;
    logic [1:0]    fuse_sync_ff;
    logic          fuse_ff;
    logic          fuse_cap_ff;
    logic [NP-1:0] pin_sync1_ff;
    logic [NP-1:0] pin_sync2_ff;
    logic [NP-1:0] pin_out_ff;
    logic [NP-1:0] pin_oe_ff;
    logic [NI-1:0] periph_in_ff;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire req     = wb_req_in.cyc & wb_req_in.stb;
    // Writes land on the edge where the master samples ack high
    wire wr_go   = req & wb_req_in.we & ack_ff;
    wire [7:0] a = wb_req_in.adr;
    wire hit_ctl = a == rpsel_pkg::CFG_CTRL_OFS;
    wire hit_key = a == rpsel_pkg::UNLOCK_OFS;
    wire hit_st  = a == rpsel_pkg::STATUS_OFS;
    // Index test one bit wider, else a count of eight pins wraps to zero
    wire hit_out = (a[7:5] == rpsel_pkg::OUT_SEL_OFS[7:5]) &&
                   ({1'b0, a[4:2]} < 4'(NP)) && (a[1:0] == 2'h0);
    wire hit_in  = (a[7:4] == rpsel_pkg::IN_SEL_OFS[7:4]) &&
                   ({1'b0, a[3:2]} < 3'(NI)) && (a[1:0] == 2'h0);
    wire [2:0] out_idx = a[4:2];
    wire [1:0] in_idx  = a[3:2];
    wire [31:0] wmerge_ctl = merge_sel(32'h0, wb_req_in.dat, wb_req_in.sel);
    wire lock_wr_val = wmerge_ctl[rpsel_pkg::LOCK_BIT];
    wire lock_lane   = wb_req_in.sel[rpsel_pkg::LOCK_BIT/8];
    wire [SW-1:0] sel_wr_val = wb_req_in.dat[SW-1:0];
    wire          sel_lane   = wb_req_in.sel[0];

    // Read mux; reserved bits and unmapped space read zero
    wire [31:0] rd_ctl = 32'(lock_ff) << rpsel_pkg::LOCK_BIT;
    wire [31:0] rd_st  = (32'(lock_ff)     << rpsel_pkg::ST_LOCK_BIT) |
                         (32'(fuse_ff)     << rpsel_pkg::ST_FUSE_BIT) |
                         (32'(unlocked_ff) << rpsel_pkg::ST_UNLOCK_BIT);
    wire [31:0] rd_mux =
        hit_ctl ? rd_ctl :
        hit_st  ? rd_st  :
        hit_out ? {28'h0, out_sel_ff[out_idx]} :
        hit_in  ? {28'h0, in_sel_ff[in_idx]} : 32'h0;

    // ------------------------------------------------------------------
    // Wishbone handshake: ack one cycle after the request, one cycle long
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0;
        end else begin
            ack_ff  <= req & ~ack_ff;
            rdat_ff <= (req & ~ack_ff & ~wb_req_in.we) ? rd_mux : 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // Unlock keys: two key writes back to back arm one lock change
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            key1_ff     <= 1'b0;
            unlocked_ff <= 1'b0;
        end else if (wr_go) begin
            key1_ff     <= hit_key && (wb_req_in.dat == rpsel_pkg::UNLOCK_KEY1);
            // Any other write disarms, so a stray store cannot slip through
            unlocked_ff <= hit_key && key1_ff &&
                           (wb_req_in.dat == rpsel_pkg::UNLOCK_KEY2);
        end
    end

    // Lock next value: needs unlock; while the fuse reads set, a set lock stays set
    always_comb begin
        nxt_lock = lock_ff;
        if (wr_go && hit_ctl && unlocked_ff && lock_lane) begin
            nxt_lock = lock_wr_val;
            if (fuse_ff && lock_ff) begin
                nxt_lock = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lock_ff <= rpsel_pkg::LOCK_RST;
        end else begin
            lock_ff <= nxt_lock;
        end
    end

    // ------------------------------------------------------------------
    // Fuse capture: synchronised, then followed every cycle from the second edge after reset release
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            // Sync stages start set so the fuse never dips before capture
            fuse_sync_ff <= {2{rpsel_pkg::FUSE_RST}};
            fuse_ff      <= rpsel_pkg::FUSE_RST;
            fuse_cap_ff  <= 1'b0;
        end else begin
            fuse_sync_ff <= {fuse_sync_ff[0],
                             cfg_word3_in[rpsel_pkg::FUSE_CFG_BIT]};
            fuse_cap_ff  <= 1'b1;
            if (fuse_cap_ff) begin
                fuse_ff <= fuse_sync_ff[1];
            end
        end
    end

    // ------------------------------------------------------------------
    // Selector registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < NP; i++) out_sel_ff[i] <= rpsel_pkg::SEL_RST;
            for (int j = 0; j < NI; j++) in_sel_ff[j]  <= rpsel_pkg::SEL_RST;
        end else if (wr_go && sel_lane && !lock_ff) begin
            if (hit_out) out_sel_ff[out_idx] <= sel_wr_val;
            if (hit_in)  in_sel_ff[in_idx]   <= sel_wr_val;
        end
    end

    // ------------------------------------------------------------------
    // Routing: per pin, its selector picks one peripheral output
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_out_ff <= '0;
            pin_oe_ff  <= '0;
        end else begin
            for (int i = 0; i < NP; i++) begin
                pin_oe_ff[i]  <= code_valid(out_sel_ff[i]);
                pin_out_ff[i] <= code_valid(out_sel_ff[i]) &&
                                 periph_out_in[out_sel_ff[i] - 4'h1];
            end
        end
    end

    // Pad inputs pass two flops before the input selectors read them
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_sync1_ff <= '0;
            pin_sync2_ff <= '0;
            periph_in_ff <= '0;
        end else begin
            pin_sync1_ff <= pin_in_in;
            pin_sync2_ff <= pin_sync1_ff;
            for (int j = 0; j < NI; j++) begin
                periph_in_ff[j] <= ({28'h0, in_sel_ff[j]} < 32'(NP)) &&
                                   pin_sync2_ff[in_sel_ff[j][2:0]];
            end
        end
    end

    assign wb_ack_out         = ack_ff;
    assign wb_dat_out         = rdat_ff;
    assign pin_out_out        = pin_out_ff;
    assign pin_oe_out         = pin_oe_ff;
    assign periph_in_out      = periph_in_ff;
    assign map_write_lock_out = lock_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    sequence s_locked_out_wr;
        wr_go && hit_out && lock_ff;
    endsequence

    a_locked_out_keep:
        assert property (s_locked_out_wr |=> out_sel_ff[$past(out_idx)] ==
                         $past(out_sel_ff[out_idx]))
        else $error("Locked selector write changed the register");
    a_locked_in_keep:
        assert property (wr_go && hit_in && lock_ff |=>
                         in_sel_ff[$past(in_idx)] ==
                         $past(in_sel_ff[in_idx]))
        else $error("Locked input select write changed the register");
    a_lock_bit_acc:
        assert property (wr_go && hit_ctl && unlocked_ff && lock_lane &&
                         !lock_ff |=> lock_ff == $past(lock_wr_val))
        else $error("Unlocked lock write not taken");
    a_lock_no_key:
        assert property (wr_go && hit_ctl && !unlocked_ff |=> $stable(lock_ff))
        else $error("Lock changed without unlock keys");
    a_one_way_hold:
        assert property (fuse_ff && lock_ff |=> lock_ff)
        else $error("Lock cleared while one-way fuse set");
    a_null_no_drive:
        assert property (out_sel_ff[0] == 4'h0 |=> !pin_oe_out[0])
        else $error("Null code drives a pin");
    a_invalid_code:
        assert property (out_sel_ff[1] > 4'(NO) |=> !pin_oe_out[1] &&
                         !pin_out_out[1])
        else $error("Unimplemented code drives a pin");
    a_route_value:
        assert property (code_valid(out_sel_ff[2]) |=> pin_oe_out[2] &&
                         pin_out_out[2] ==
                         $past(periph_out_in[out_sel_ff[2] - 4'h1]))
        else $error("Pin does not follow selected output");
    a_fuse_reset_set:
        assert property (!fuse_cap_ff |-> fuse_ff)
        else $error("Fuse not read as set before capture");
    a_ack_timing:
        assert property (req && !ack_ff |=> ack_ff ##1 !ack_ff)
        else $error("Wishbone ack not one cycle after request");

endmodule

/* File: dv/rpsel_far_model.sv */
// Far-side model: peripheral outputs and pad levels around the fabric.
// Assumes the bench sets both patterns and holds them while it checks.
`timescale 1ns/1ps
module rpsel_far_model (
    input  wire logic [rpsel_pkg::NUM_POUT-1:0] pout_pat_in,
    input  wire logic                           clk_in,
    input  wire logic [7:0]                     pad_pat_in,
    input  wire logic [7:0]                     pin_out_in,
    input  wire logic [7:0]                     pin_oe_in,
    output logic [rpsel_pkg::NUM_POUT-1:0]      periph_out_out,
    output logic [7:0]                          pin_in_out
);
    // Peripherals share the system clock, so they move after an edge
    always_ff @(posedge clk_in) begin
        periph_out_out <= pout_pat_in;
    end

    // Wire level: a driven pin wins over the external source
    assign pin_in_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & pad_pat_in);
endmodule

/* File: dv/rpsel_top_tb.sv */
// Self-checking bench for the remap fabric, one task per scenario.
// Assumes a classic Wishbone slave with a one-cycle registered ack.
`timescale 1ns/1ps
module rpsel_top_tb;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                     sys_clk;
    logic                     arst_n;
    rpsel_pkg::rpsel_wb_req_t req;
    logic                     ack;
    logic [31:0]              rdat;
    logic [31:0]              cfg;
    logic [9:0]               pout;
    logic [9:0]               pout_pat;
    logic [7:0]               pad_pat;
    logic [7:0]               pin_out;
    logic [7:0]               pin_oe;
    logic [7:0]               pin_in;
    logic [3:0]               pin_route;
    logic                     lock;
    logic [31:0]              rd;
    int                       n_fail;
    int                       samples_checked;

    rpsel_top rpsel_top_i (.sys_clk_in(sys_clk), .arst_n_in(arst_n),
        .wb_req_in(req), .wb_ack_out(ack), .wb_dat_out(rdat),
        .cfg_word3_in(cfg), .periph_out_in(pout), .pin_out_out(pin_out),
        .pin_oe_out(pin_oe), .pin_in_in(pin_in),
        .periph_in_out(pin_route), .map_write_lock_out(lock));
    rpsel_far_model rpsel_far_model_i (.clk_in(sys_clk),
        .pout_pat_in(pout_pat), .pad_pat_in(pad_pat), .pin_out_in(pin_out),
        .pin_oe_in(pin_oe), .periph_out_out(pout), .pin_in_out(pin_in));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One classic cycle; the idle edge at the end keeps stb low a cycle
    task automatic bus(input logic we, input logic [7:0] adr,
                       input logic [31:0] dat);
        int n;
        n = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf,
                 dat: dat};
        @(posedge sys_clk);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 50) n_fail++;
        rd = rdat;
        req <= '0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        bus(1'b1, adr, dat);
    endtask

    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        chk(rd, exp);
    endtask

    function automatic logic [7:0] sel_adr(input int i);
        return rpsel_pkg::OUT_SEL_OFS + 8'(4 * i);
    endfunction

    // Pins and pad synchronisers need up to four edges to show a change
    task automatic settle();
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic do_reset(input logic fuse);
        cfg <= {2'h0, fuse, 29'h0};
        arst_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask

    // Software side: keys first, else the lock write must do nothing
    task automatic set_lock(input logic keys, input logic val);
        if (keys) begin
            wr(rpsel_pkg::UNLOCK_OFS, rpsel_pkg::UNLOCK_KEY1);
            wr(rpsel_pkg::UNLOCK_OFS, rpsel_pkg::UNLOCK_KEY2);
        end
        wr(rpsel_pkg::CFG_CTRL_OFS, 32'(val) << rpsel_pkg::LOCK_BIT);
        settle();
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // null routes and fuse status after reset
    task automatic t_reset_state();
        for (int i = 0; i < 8; i++) begin
            rdc(sel_adr(i), 32'h0);
        end
        chk(32'(pin_oe), 32'h0);
        rdc(rpsel_pkg::STATUS_OFS, 32'h2);
        wr(8'hfc, 32'hffff_ffff);
        rdc(8'hfc, 32'h0);
    endtask

    // every code 1..15, per-pin, live following of source
    task automatic t_route();
        int p;
        for (int c = 1; c < 16; c++) begin
            p = c % 8;
            wr(sel_adr(p), 32'(c));
            settle();
            rdc(sel_adr(p), 32'(c));
            chk(32'(pin_oe[p]), 32'(c <= rpsel_pkg::NUM_POUT));
            if (c <= rpsel_pkg::NUM_POUT) begin
                chk(32'(pin_out[p]), 32'(pout_pat[c-1]));
            end
        end
        pout_pat <= ~pout_pat;
        settle();
        chk(32'(pin_out[1]), 32'(pout_pat[8]));
        // Unimplemented code on a pin that was driving must drop it
        wr(sel_adr(1), 32'hb);
        settle();
        chk(32'(pin_oe[1]), 32'h0);
        chk(32'(pin_out[1]), 32'h0);
        wr(sel_adr(1), 32'h9);
        wr(rpsel_pkg::IN_SEL_OFS, 32'h5);
        pad_pat <= 8'h20;
        settle();
        chk(32'(pin_route[0]), 32'h1);
    endtask

    // ..key sequence, blocked writes, one-way fuse, reset
    task automatic t_lock_fuse();
        set_lock(1'b0, 1'b1);
        chk(32'(lock), 32'h0);
        set_lock(1'b1, 1'b1);
        chk(32'(lock), 32'h1);
        wr(sel_adr(1), 32'h3);
        wr(rpsel_pkg::IN_SEL_OFS, 32'h2);
        rdc(sel_adr(1), 32'h9);
        rdc(rpsel_pkg::IN_SEL_OFS, 32'h5);
        set_lock(1'b1, 1'b0);
        chk(32'(lock), 32'h1);
        do_reset(1'b1);
        chk(32'(lock), 32'h0);
        wr(sel_adr(1), 32'h3);
        rdc(sel_adr(1), 32'h3);
    endtask

    // with the fuse clear the lock may be dropped again
    task automatic t_fuse_off();
        do_reset(1'b0);
        rdc(rpsel_pkg::STATUS_OFS, 32'h0);
        set_lock(1'b1, 1'b1);
        chk(32'(lock), 32'h1);
        set_lock(1'b1, 1'b0);
        chk(32'(lock), 32'h0);
        wr(sel_adr(2), 32'h4);
        settle();
        chk(32'(pin_out[2]), 32'(pout_pat[3]));
    endtask

    // ------------------------------------------------------------------
    // Clock, sequence and watchdog
    // ------------------------------------------------------------------
    // 200 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Main sequence; all inputs valued at time zero
    initial begin
        n_fail = 0;
        samples_checked = 0;
        req = '0;
        cfg = 32'h0;
        pout_pat = 10'h2b5;
        pad_pat = 8'h00;
        arst_n = 1'b0;
        do_reset(1'b1);
        t_reset_state();
        t_route();
        t_lock_fuse();
        t_fuse_off();
        report_and_stop();
    end

    // Whole run is well under a thousand cycles; this cuts a hang
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        report_and_stop();
    end
endmodule
